/* File: rtl/arc_regs.vh */
// register map and constants of the alarm relay output control
// assumes a 32-bit axi4-lite master and one 100 MHz clock
//
// Behaviour
// - each channel has two independent alarm flags
// - output combines channels with OR or AND
// - source selects none, alarm 1, alarm 2 or both
// - combined source needs both alarms together
// - normally open: closed while function is one
// - normally closed: open while function is one
// - zero delay switches at once
// - nonzero delay switches after full delay
// - switch once net time of condition reaches delay
// - hold new state for its hold time
// - during hold ignore alarms, no counting
// - counter counts up while function differs from state, down otherwise
// - over threshold: set at t+h, clear t-h
// - under threshold: set at t-h, clear t+h
`ifndef ARC_REGS_VH
`define ARC_REGS_VH

// ----------------------------------------------------------------
// byte offsets
// ----------------------------------------------------------------
`define ARC_OFS_CTRL 8'h00
`define ARC_OFS_SRC 8'h04
`define ARC_OFS_STAT 8'h08
`define ARC_OFS_IRQ_STAT 8'h0c
`define ARC_OFS_IRQ_CLR 8'h10
`define ARC_OFS_IRQ_EN 8'h14
`define ARC_OFS_TICK 8'h18
`define ARC_OFS_OUT_BASE 8'h20
`define ARC_OFS_CH_BASE 8'h80
// per output: 4 words (close delay, open delay, closed hold, open hold)
// per channel: 3 words in a 4-word slot (mode, thr1, hys1 | thr2, hys2 packed)

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define ARC_CTRL_EN_BIT 0
`define ARC_SRC_NONE 2'h0
`define ARC_SRC_AL1 2'h1
`define ARC_SRC_AL2 2'h2
`define ARC_SRC_BOTH 2'h3
`define ARC_AMODE_OFF 2'h0
`define ARC_AMODE_OVER 2'h1
`define ARC_AMODE_UNDER 2'h2

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define ARC_RST_TICK_DIV 32'h000f4240
`define ARC_TICK_NS 10000000
`define ARC_CLK_NS 10
`define ARC_TICK_CYC (`ARC_TICK_NS / `ARC_CLK_NS)

`endif

/* File: rtl/arc_relay_ctrl.v */
// alarm relay output control: alarms per channel, combining, delays, holds
// assumes readings arrive synchronous to clk_sys from the measurement logic
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "arc_regs.vh"

module arc_relay_ctrl #(
  parameter NCH = 4,
  parameter NOUT = 2,
  parameter [31:0] TICK_DIV = `ARC_TICK_CYC
) (
  // clock and reset
  input wire clk_sys,
  input wire srst,
  input wire ce,
  // readings, NCH signed 16-bit values packed
  input wire [NCH*16-1:0] reading,
  // relays
  output reg [NOUT-1:0] relay_closed,
  output reg irq,
  // axi4-lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg ctrl_en_r;
  reg [31:0] tick_div_r;
  reg [NOUT-1:0] func_and_r;
  reg [NOUT-1:0] mode_nc_r;
  reg [2*NCH*NOUT-1:0] src_r;
  reg [15:0] close_dly_r [0:NOUT-1];
  reg [15:0] open_dly_r [0:NOUT-1];
  reg [15:0] closed_hold_r [0:NOUT-1];
  reg [15:0] open_hold_r [0:NOUT-1];
  reg [1:0] amode1_r [0:NCH-1];
  reg [1:0] amode2_r [0:NCH-1];
  reg [15:0] thr1_r [0:NCH-1];
  reg [15:0] hys1_r [0:NCH-1];
  reg [15:0] thr2_r [0:NCH-1];
  reg [15:0] hys2_r [0:NCH-1];
  reg [NCH-1:0] al1_r;
  reg [NCH-1:0] al2_r;
  reg [NOUT-1:0] func_r;
  reg [15:0] dcnt_r [0:NOUT-1];
  reg [15:0] hcnt_r [0:NOUT-1];
  reg [NOUT-1:0] irq_stat_r;
  reg [NOUT-1:0] irq_en_r;
  reg [31:0] tick_cnt_r;
  reg tick_r;
  reg [7:0] wr_addr;
  reg aw_have_r;
  reg w_have_r;
  reg [7:0] aw_addr_r;
  reg [31:0] w_data_r;
  // a write lands only once both channels are captured and no response is pending
  wire wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;
  wire [31:0] wdat = w_have_r ? w_data_r : s_axi_wdata;

  // ----------------------------------------------------------------
  // hysteresis alarm evaluation
  // ----------------------------------------------------------------
  function alarm_next;
    input [1:0] mode;
    input signed [15:0] val;
    input signed [15:0] thr;
    input signed [15:0] hys;
    input cur;
    reg signed [17:0] hi;
    reg signed [17:0] lo;
    begin
      hi = thr + hys;
      lo = thr - hys;
      case (mode)
        `ARC_AMODE_OVER: alarm_next = cur ? (val > lo) : (val >= hi);
        `ARC_AMODE_UNDER: alarm_next = cur ? (val < hi) : (val <= lo);
        default: alarm_next = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // tick divider, delay and hold times count ticks
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (srst) begin
      tick_cnt_r <= 32'h00000000;
      tick_r <= 1'b0;
    end else if (ce) begin
      tick_r <= 1'b0;
      if (tick_cnt_r + 32'h00000001 >= tick_div_r) begin
        tick_cnt_r <= 32'h00000000;
        tick_r <= 1'b1;
      end else begin
        tick_cnt_r <= tick_cnt_r + 32'h00000001;
      end
    end
  end

  genvar gc, go;
  generate
    for (gc = 0; gc < NCH; gc = gc + 1) begin : g_ch
      wire signed [15:0] val = reading[gc*16 +: 16];
      always @(posedge clk_sys) begin
        if (srst) begin
          al1_r[gc] <= 1'b0;
          al2_r[gc] <= 1'b0;
        end else if (ce) begin
          al1_r[gc] <= alarm_next(amode1_r[gc], val, thr1_r[gc], hys1_r[gc], al1_r[gc]);
          al2_r[gc] <= alarm_next(amode2_r[gc], val, thr2_r[gc], hys2_r[gc], al2_r[gc]);
        end
      end
    end

    for (go = 0; go < NOUT; go = go + 1) begin : g_out
      reg any_c;
      reg all_c;
      reg att;
      reg chal;
      integer k;
      always @* begin
        any_c = 1'b0;
        all_c = 1'b1;
        att = 1'b0;
        chal = 1'b0;
        for (k = 0; k < NCH; k = k + 1) begin
          case (src_r[(go*NCH+k)*2 +: 2])
            `ARC_SRC_AL1: chal = al1_r[k];
            `ARC_SRC_AL2: chal = al2_r[k];
            `ARC_SRC_BOTH: chal = al1_r[k] & al2_r[k];
            default: chal = 1'b0;
          endcase
          if (src_r[(go*NCH+k)*2 +: 2] != `ARC_SRC_NONE) begin
            att = 1'b1;
            any_c = any_c | chal;
            all_c = all_c & chal;
          end
        end
      end
      wire fn = func_and_r[go] ? (att & all_c) : any_c;
      // logical state: 1 = function asserted state reached
      wire want = fn;
      wire act = relay_closed[go] ^ mode_nc_r[go];
      wire [15:0] dly = act ? open_dly_r[go] : close_dly_r[go];
      always @(posedge clk_sys) begin
        if (srst) begin
          func_r[go] <= 1'b0;
          relay_closed[go] <= 1'b0;
          dcnt_r[go] <= 16'h0000;
          hcnt_r[go] <= 16'h0000;
          irq_stat_r[go] <= 1'b0;
        end else if (ce) begin
          func_r[go] <= fn;
          if (!ctrl_en_r) begin
            relay_closed[go] <= mode_nc_r[go];
            dcnt_r[go] <= 16'h0000;
            hcnt_r[go] <= 16'h0000;
          end else if (hcnt_r[go] != 16'h0000) begin
            if (tick_r)
              hcnt_r[go] <= hcnt_r[go] - 16'h0001;
          end else if (want == act) begin
            if (tick_r && dcnt_r[go] != 16'h0000)
              dcnt_r[go] <= dcnt_r[go] - 16'h0001;
          end else if (dly == 16'h0000 || (tick_r && dcnt_r[go] + 16'h0001 >= dly)) begin
            // normally open closes on one, normally closed opens on one
            relay_closed[go] <= want ^ mode_nc_r[go];
            dcnt_r[go] <= 16'h0000;
            hcnt_r[go] <= want ? closed_hold_r[go] : open_hold_r[go];
            irq_stat_r[go] <= 1'b1;
          end else if (tick_r) begin
            dcnt_r[go] <= dcnt_r[go] + 16'h0001;
          end
          if (wr_go && wr_addr == `ARC_OFS_IRQ_CLR && wdat[go] && !(irq_stat_r[go] == 1'b0))
            if (!(hcnt_r[go] == 16'h0000 && want != act && ctrl_en_r &&
                  (dly == 16'h0000 || (tick_r && dcnt_r[go] + 16'h0001 >= dly))))
              irq_stat_r[go] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  always @* wr_addr = aw_have_r ? aw_addr_r : s_axi_awaddr;
  wire [7:0] orel = wr_addr - `ARC_OFS_OUT_BASE;
  wire [7:0] crel = wr_addr - `ARC_OFS_CH_BASE;
  wire wr_known = wr_addr == `ARC_OFS_CTRL || wr_addr == `ARC_OFS_SRC || wr_addr == `ARC_OFS_IRQ_CLR ||
    wr_addr == `ARC_OFS_IRQ_EN || wr_addr == `ARC_OFS_TICK ||
    (wr_addr >= `ARC_OFS_OUT_BASE && orel[7:4] < NOUT) || (wr_addr >= `ARC_OFS_CH_BASE && crel[7:4] < NCH);
  integer i;

  always @(posedge clk_sys) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      ctrl_en_r <= 1'b0;
      tick_div_r <= TICK_DIV;
      func_and_r <= {NOUT{1'b0}};
      mode_nc_r <= {NOUT{1'b0}};
      src_r <= {2*NCH*NOUT{1'b0}};
      irq_en_r <= {NOUT{1'b0}};
      for (i = 0; i < NOUT; i = i + 1) begin
        close_dly_r[i] <= 16'h0000;
        open_dly_r[i] <= 16'h0000;
        closed_hold_r[i] <= 16'h0000;
        open_hold_r[i] <= 16'h0000;
      end
      for (i = 0; i < NCH; i = i + 1) begin
        amode1_r[i] <= 2'h0;
        amode2_r[i] <= 2'h0;
        thr1_r[i] <= 16'h0000;
        hys1_r[i] <= 16'h0000;
        thr2_r[i] <= 16'h0000;
        hys2_r[i] <= 16'h0000;
      end
    end else if (ce) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      // ready is a one-cycle pulse when each channel is taken
      if (s_axi_awvalid && !aw_have_r && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_r && !s_axi_wready) begin
        s_axi_wready <= 1'b1;
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
      end
      if (aw_have_r && w_have_r && !s_axi_bvalid) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? 2'h0 : 2'h2;
        if (wr_addr == `ARC_OFS_CTRL && s_axi_wstrb[0]) begin
          ctrl_en_r <= wdat[`ARC_CTRL_EN_BIT];
          func_and_r <= wdat[8 +: NOUT];
          mode_nc_r <= wdat[16 +: NOUT];
        end
        if (wr_addr == `ARC_OFS_SRC)
          src_r <= wdat[2*NCH*NOUT-1:0];
        if (wr_addr == `ARC_OFS_IRQ_EN)
          irq_en_r <= wdat[NOUT-1:0];
        if (wr_addr == `ARC_OFS_TICK)
          tick_div_r <= wdat;
        for (i = 0; i < NOUT; i = i + 1) begin
          if (wr_addr == `ARC_OFS_OUT_BASE + 8'h10 * i[7:0]) close_dly_r[i] <= wdat[15:0];
          if (wr_addr == `ARC_OFS_OUT_BASE + 8'h10 * i[7:0] + 8'h04) open_dly_r[i] <= wdat[15:0];
          if (wr_addr == `ARC_OFS_OUT_BASE + 8'h10 * i[7:0] + 8'h08) closed_hold_r[i] <= wdat[15:0];
          if (wr_addr == `ARC_OFS_OUT_BASE + 8'h10 * i[7:0] + 8'h0c) open_hold_r[i] <= wdat[15:0];
        end
        for (i = 0; i < NCH; i = i + 1) begin
          if (wr_addr == `ARC_OFS_CH_BASE + 8'h10 * i[7:0]) begin
            amode1_r[i] <= wdat[1:0];
            amode2_r[i] <= wdat[9:8];
          end
          if (wr_addr == `ARC_OFS_CH_BASE + 8'h10 * i[7:0] + 8'h04) begin
            thr1_r[i] <= wdat[15:0];
            hys1_r[i] <= wdat[31:16];
          end
          if (wr_addr == `ARC_OFS_CH_BASE + 8'h10 * i[7:0] + 8'h08) begin
            thr2_r[i] <= wdat[15:0];
            hys2_r[i] <= wdat[31:16];
          end
        end
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read side, irq output
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(irq_stat_r & irq_en_r);
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (s_axi_araddr)
          `ARC_OFS_CTRL: s_axi_rdata <= {{(16-NOUT){1'b0}}, mode_nc_r, {(8-NOUT){1'b0}}, func_and_r,
                                         7'h00, ctrl_en_r};
          `ARC_OFS_SRC: s_axi_rdata <= {{(32-2*NCH*NOUT){1'b0}}, src_r};
          `ARC_OFS_STAT: s_axi_rdata <= {{(8-NOUT){1'b0}}, func_r, {(8-NCH){1'b0}}, al2_r,
                                         {(8-NCH){1'b0}}, al1_r, {(8-NOUT){1'b0}}, relay_closed};
          `ARC_OFS_IRQ_STAT: s_axi_rdata <= {{(32-NOUT){1'b0}}, irq_stat_r};
          `ARC_OFS_IRQ_EN: s_axi_rdata <= {{(32-NOUT){1'b0}}, irq_en_r};
          `ARC_OFS_TICK: s_axi_rdata <= tick_div_r;
          `ARC_OFS_IRQ_CLR: s_axi_rdata <= 32'h00000000;
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // arc_relay_ctrl
`default_nettype wire

/* File: verification/arc_relay_load.sv */
// far-side model: electronic relay contact and the load behind it
// assumes relay_closed is a level drive in the clk_sys domain
`timescale 1ns/1ns
`default_nettype none
module arc_relay_load #(
  parameter NOUT = 2
) (
  // drive from the control block
  input wire logic clk_sys,
  input wire logic [NOUT-1:0] relay_closed,
  // load side
  output logic [NOUT-1:0] load_on
);
  // solid-state contact settles one clock after its drive changes
  always @(posedge clk_sys) begin
    load_on <= relay_closed;
  end
endmodule // arc_relay_load
`default_nettype wire

/* File: verification/arc_relay_ctrl_asserts.sv */
// checker of the relay control block: reset state and bus handshakes
// assumes it is bound to arc_relay_ctrl, one clock, synchronous reset
`timescale 1ns/1ns
`default_nettype none
module arc_relay_ctrl_chk #(
  parameter NOUT = 2
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // outputs
  input wire logic [NOUT-1:0] relay_closed,
  input wire logic irq,
  // bus
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_reset_clears: assert property (disable iff (1'b0) srst |=> relay_closed == 0 && !irq && !s_axi_bvalid)
    else $error("outputs not cleared by reset");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed early");
  a_aw_w_paired: assert property (s_axi_awready |-> s_axi_wready)
    else $error("address taken without data");
  a_write_answer: assert property (s_axi_awready |=> s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arready |-> s_axi_rvalid)
    else $error("read data late");
  a_ready_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("read ready longer than one cycle");
  a_resp_code: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0 || s_axi_rresp == 2'h2)
    else $error("illegal read response code");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_relay_close: cover property ($rose(relay_closed[0]));
  c_irq: cover property ($rose(irq));
endmodule // arc_relay_ctrl_chk

bind arc_relay_ctrl arc_relay_ctrl_chk #(.NOUT(NOUT)) u_chk (
  .clk_sys(clk_sys),
  .srst(srst),
  .relay_closed(relay_closed),
  .irq(irq),
  .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp)
);
`default_nettype wire

/* File: verification/tb_alarm_relay_output_control.sv */
// testbench: registers over axi4-lite, readings driven per channel
// assumes two channels, two outputs and a tick every 4 clocks
`timescale 1ns/1ns
`default_nettype none
module tb_alarm_relay_output_control;
  logic clk_sys = 0;
  logic srst = 1;
  logic [31:0] reading = {16'd70, 16'd70};
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, d;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic ce = 1;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, r, b, relay_closed, load_on;
  logic [31:0] rdata;
  int fail_count = 0, checks = 0;
  arc_relay_ctrl #(.NCH(2), .NOUT(2), .TICK_DIV(32'h4)) i_dut (.clk_sys(clk_sys), .srst(srst), .ce(ce),
    .reading(reading), .relay_closed(relay_closed), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  arc_relay_load #(.NOUT(2)) u_load (.clk_sys(clk_sys), .relay_closed(relay_closed), .load_on(load_on));
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // ready-side slow on purpose so the response has to wait
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 1;
    @(posedge clk_sys);
    b = bresp;
    bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1;
    do begin
      @(posedge clk_sys);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 1;
    @(posedge clk_sys);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(d & m, e);
  endtask
  task automatic rset(input int ch, input logic [15:0] v);
    reading[16*ch +: 16] <= v;
    repeat (12) @(posedge clk_sys);
  endtask
  task automatic wrel(input int o, input logic v, input int n);
    int i;
    for (i = 0; i < n && relay_closed[o] !== v; i++) @(posedge clk_sys);
    chk(relay_closed[o], v);
  endtask
  task automatic stay(input int o, input logic v, input int n);
    logic ok;
    ok = 1;
    repeat (n) begin
      @(posedge clk_sys);
      ok &= (relay_closed[o] === v);
    end
    chk(ok, 1);
  endtask
  task automatic end_sim;
    if (fail_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys);
    srst <= 0;
    @(posedge clk_sys);
    rdc(8'h00, 32'hffffffff, 0);
    rdc(8'h08, 32'hffffffff, 0);
    rd(8'h7c);
    chk(r, 2'h2);
    wr(8'h7c, 32'h0);
    chk(b, 2'h2);
    // control byte without its strobe must leave the register untouched
    wstrb <= 4'he;
    wr(8'h00, 32'h1);
    wstrb <= 4'hf;
    rdc(8'h00, 32'hffffffff, 0);
    wr(8'h80, 32'h201);
    wr(8'h84, 32'h000a0064);
    wr(8'h88, 32'h00050032);
    wr(8'h90, 32'h1);
    wr(8'h94, 32'h000a0064);
    wr(8'h04, 32'h51);
    wr(8'h14, 32'h1);
    wr(8'h00, 32'h201);
    chk(b, 2'h0);
    rdc(8'h00, 32'hffffffff, 32'h201);
    rset(0, 120);
    wrel(0, 1, 12);
    stay(1, 0, 8);
    chk(irq, 1);
    rdc(8'h0c, 32'h1, 32'h1);
    wr(8'h10, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk(irq, 0);
    rdc(8'h08, 32'h30300, 32'h100);
    rset(1, 120);
    wrel(1, 1, 12);
    rset(0, 95);
    stay(0, 1, 16);
    wr(8'h14, 32'h0);
    rset(0, 85);
    wrel(0, 0, 12);
    wrel(1, 0, 12);
    chk(irq, 0);
    rdc(8'h0c, 32'h1, 32'h1);
    wr(8'h10, 32'h1);
    rdc(8'h0c, 32'h1, 32'h0);
    rset(0, 40);
    rdc(8'h08, 32'h10100, 32'h10000);
    rset(0, 52);
    rdc(8'h08, 32'h10000, 32'h10000);
    rset(0, 60);
    rdc(8'h08, 32'h10000, 32'h0);
    wr(8'h80, 32'h101);
    wr(8'h04, 32'h52);
    wrel(0, 1, 12);
    wr(8'h04, 32'h53);
    wrel(0, 0, 12);
    rset(0, 120);
    wrel(0, 1, 12);
    wr(8'h00, 32'h10201);
    wrel(0, 0, 12);
    rset(0, 70);
    wrel(0, 1, 12);
    wr(8'h20, 32'h8);
    wr(8'h00, 32'h201);
    wrel(0, 0, 12);
    rset(0, 120);
    stay(0, 0, 4);
    rset(0, 70);
    repeat (36) @(posedge clk_sys);
    wr(8'h28, 32'ha);
    rset(0, 120);
    stay(0, 0, 8);
    wrel(0, 1, 48);
    reading[15:0] <= 16'd70;
    stay(0, 1, 28);
    chk(load_on[0], 1);
    wrel(0, 0, 40);
    @(posedge clk_sys);
    chk(load_on[0], 0);
    // clock enable low freezes alarms, delay counting and the relay
    ce <= 0;
    reading[15:0] <= 16'd120;
    repeat (60) @(posedge clk_sys);
    chk(relay_closed[0], 0);
    ce <= 1;
    wrel(0, 1, 60);
    end_sim;
  end
  initial begin
    #200000;
    fail_count++;
    end_sim;
  end
endmodule // tb_alarm_relay_output_control
`default_nettype wire
